// File: core/sleep_ctrl.sv
// Sleep mode controller: normal/sleep scheduling, wake and exit logic.
// Assumes all inputs synchronous to sys_clk and a single-cycle register port.
//
// Functional notes
// - Normal: current every 3 ms, voltage 63 ms
// - Fast conversion bit doubles both rates
// - Power-up bit, then subcommands allow/forbid sleep
// - Status shows sleep permitted and sleep active
// - Low current plus permission enters sleep
// - Comparator protections keep running in sleep
// - Sleep: full measurement set per voltage time
// - 4 s current integration 1 s after set
// - Voltage time expiry aborts integration, measures
// - Sleep temperature checks use interval measurements
// - Fault, current, charger, disable, pin exit sleep
// - Current exit: FETs on now, loop waits
// - Wake comparator sample over threshold exits fast
// - Integrated current above sleep threshold exits
// - Wake rate field picks 48/24/12/6 ms
// - Pack above stack plus delta exits sleep
// - Hysteresis time blocks re-entry after exit
// - Sleep FET drive chosen by option bits
// - Shutdown disables everything and loses registers; here the 1 s tick, sleep sequencing, follower and register port stay live
// - Sleep decision evaluated once per second
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module sleep_ctrl
  import sleep_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [15:0] rdata,
  input  wire logic [15:0] cc_current,
  input  wire logic [15:0] lp_current,
  input  wire logic        meas_done,
  input  wire logic [15:0] pack_mv,
  input  wire logic [15:0] stack_mv,
  input  wire logic        cmp_fault,
  input  wire logic        fw_fault,
  input  wire logic        rst_pin_short,
  input  wire logic        shutdown_req,
  output logic             sleep_mode,
  output logic             i_sample,
  output logic             v_sample,
  output logic             half_res,
  output logic             wake_sample,
  output logic             meas_start,
  output logic             lp_start,
  output logic             lp_abort,
  output logic             temp_eval,
  output logic             loop_run,
  output logic             tick_1s,
  output logic             cmp_prot_en,
  output logic             discharge_switch,
  output logic             discharge_follower,
  output logic             charge_switch,
  output logic             precharge_switch,
  output logic             predischarge_switch,
  output logic             first_regulator,
  output logic             second_regulator
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [13:0] tick_cnt;
    logic        tick;
    logic [10:0] sec_cnt;
    logic        sec;
    logic [2:0]  i_cnt;
    logic [6:0]  v_cnt;
    logic [6:0]  wk_cnt;
    mode_e       st;
    logic [7:0]  vt_cnt;
    logic [7:0]  hyst_cnt;
    logic [2:0]  ph_cnt;
    logic        sleep_en;
    logic [5:0]  pcfg;
    logic [15:0] slp_i;
    logic [15:0] wak_i;
    logic [7:0]  vtime;
    logic [7:0]  hyst;
    logic [15:0] delta;
    logic [15:0] chgv;
    logic        exit_req;
    logic        loop_hold;
    logic        shut;
    logic [15:0] rdata;
    logic        i_smp;
    logic        v_smp;
    logic        wk_smp;
    logic        m_start;
    logic        l_start;
    logic        l_abort;
    logic        t_eval;
  } state_s;

  state_s s_q;
  state_s s_d;

  // Magnitude of a signed reading
  function automatic logic [15:0] mag(input logic [15:0] v);
    mag = v[15] ? 16'(-v) : v;
  endfunction : mag

  logic in_sleep;
  logic wake_hit;
  logic [6:0] wk_period;
  logic [2:0] i_per;
  logic [6:0] v_per;
  logic [16:0] pack_lim;

  // Derived conditions
  assign in_sleep = (s_q.st != ST_NORM);
  assign wake_hit = in_sleep && s_q.wk_smp && (mag(cc_current) > s_q.wak_i);
  assign pack_lim = {1'b0, stack_mv} + {1'b0, s_q.delta};
  // Fast conversion halves both periods
  assign i_per = s_q.pcfg[PC_FAST] ? 3'(I_MS_X2 / 2) : 3'(I_MS_X2);
  assign v_per = s_q.pcfg[PC_FAST] ? 7'(V_MS_X2 / 2) : 7'(V_MS_X2);

  // Wake comparator period from the rate field
  always_comb begin
    case (s_q.pcfg[PC_WK_LO+:2])
      2'b00:   wk_period = WK_P0;
      2'b01:   wk_period = WK_P1;
      2'b10:   wk_period = WK_P2;
      default: wk_period = WK_P3;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    s_d.sec = 1'b0;
    s_d.i_smp = 1'b0;
    s_d.v_smp = 1'b0;
    s_d.wk_smp = 1'b0;
    s_d.m_start = 1'b0;
    s_d.l_start = 1'b0;
    s_d.l_abort = 1'b0;
    s_d.t_eval = 1'b0;
    s_d.rdata = 16'h0000;

    // Base tick and one-second boundary
    if (s_q.tick_cnt == 14'(TICK_CYCLES - 1)) begin
      s_d.tick_cnt = 14'h0000;
      s_d.tick = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 14'h0001;
    end
    if (s_q.tick) begin
      if (s_q.sec_cnt == 11'(SEC_TICKS - 1)) begin
        s_d.sec_cnt = 11'h000;
        s_d.sec = 1'b1;
      end else begin
        s_d.sec_cnt = s_q.sec_cnt + 11'h001;
      end
    end

    // Normal mode sample scheduling
    if (!in_sleep && s_q.tick) begin
      s_d.i_cnt = (s_q.i_cnt >= i_per - 3'h1) ? 3'h0 : s_q.i_cnt + 3'h1;
      s_d.i_smp = (s_q.i_cnt >= i_per - 3'h1);
      s_d.v_cnt = (s_q.v_cnt >= v_per - 7'h01) ? 7'h00 : s_q.v_cnt + 7'h01;
      s_d.v_smp = (s_q.v_cnt >= v_per - 7'h01);
    end

    // Reduced-power wake comparator sampling
    if (in_sleep && s_q.tick) begin
      s_d.wk_cnt = (s_q.wk_cnt >= wk_period - 7'h01) ? 7'h00 : s_q.wk_cnt + 7'h01;
      s_d.wk_smp = (s_q.wk_cnt >= wk_period - 7'h01);
    end

    // Hysteresis counts down on the second tick
    if (s_q.sec && s_q.hyst_cnt != 8'h00) begin
      s_d.hyst_cnt = s_q.hyst_cnt - 8'h01;
    end
    // Standard loop restarts only at a second boundary
    if (s_q.sec) begin
      s_d.loop_hold = 1'b0;
    end
    // Normal temperature checks run once per second
    if (!in_sleep) begin
      s_d.t_eval = s_q.sec;
    end

    // Sleep exit causes latched for the next second
    if (in_sleep && (fw_fault || cmp_fault || rst_pin_short)) begin
      s_d.exit_req = 1'b1;
    end

    // Sleep measurement sequence
    case (s_q.st)
      ST_NORM: begin
        // Entry decision on the second boundary
        if (s_q.sec && s_q.sleep_en && s_q.hyst_cnt == 8'h00 &&
            mag(cc_current) < s_q.slp_i) begin
          s_d.st = ST_MEAS;
          s_d.m_start = 1'b1;
          s_d.vt_cnt = s_q.vtime;
          s_d.exit_req = 1'b0;
          s_d.wk_cnt = 7'h00;
        end
      end
      ST_MEAS: begin
        if (meas_done) begin
          s_d.st = ST_GAP;
          s_d.ph_cnt = 3'(GAP_SECS);
          s_d.t_eval = 1'b1;
          // Charger detect from pack and stack
          if ({1'b0, pack_mv} > pack_lim && stack_mv < s_q.chgv) begin
            s_d.exit_req = 1'b1;
          end
        end
      end
      ST_GAP: begin
        if (s_q.sec) begin
          if (s_q.ph_cnt <= 3'h1) begin
            s_d.st = ST_LP;
            s_d.l_start = 1'b1;
            s_d.ph_cnt = 3'(LP_SECS);
          end else begin
            s_d.ph_cnt = s_q.ph_cnt - 3'h1;
          end
        end
      end
      ST_LP: begin
        if (s_q.sec) begin
          if (s_q.ph_cnt <= 3'h1) begin
            s_d.st = ST_IDLE;
            // Integrated current over threshold
            if (mag(lp_current) > s_q.slp_i) begin
              s_d.exit_req = 1'b1;
            end
          end else begin
            s_d.ph_cnt = s_q.ph_cnt - 3'h1;
          end
        end
      end
      ST_IDLE: begin
      end
      default: begin
        s_d.st = ST_NORM;
      end
    endcase

    // Voltage time interval drives the full set
    if (in_sleep && s_q.sec) begin
      if (s_q.vt_cnt <= 8'h01) begin
        s_d.vt_cnt = s_q.vtime;
        if (s_q.st != ST_MEAS) begin
          s_d.m_start = 1'b1;
          s_d.st = ST_MEAS;
          // Integration in flight gives way
          s_d.l_abort = (s_q.st == ST_LP) && !(s_q.ph_cnt <= 3'h1);
        end
      end else begin
        s_d.vt_cnt = s_q.vt_cnt - 8'h01;
      end
    end

    // Register writes
    if (wr_stb) begin
      case (addr)
        A_CMD: begin
          if (wdata == SUB_SLP_EN) begin
            s_d.sleep_en = 1'b1;
          end else if (wdata == SUB_SLP_DIS) begin
            s_d.sleep_en = 1'b0;
            if (in_sleep) begin
              s_d.exit_req = 1'b1;
            end
          end
        end
        A_PCFG:  s_d.pcfg = wdata[5:0];
        A_SLPI:  s_d.slp_i = wdata;
        A_WAKI:  s_d.wak_i = wdata;
        A_VTIME: s_d.vtime = wdata[7:0];
        A_HYST:  s_d.hyst = wdata[7:0];
        A_DELTA: s_d.delta = wdata;
        A_CHGV:  s_d.chgv = wdata;
        default: begin
        end
      endcase
    end

    // Exits: fast on wake comparator, else at the second
    if (wake_hit || (in_sleep && s_q.sec && s_q.exit_req)) begin
      s_d.st = ST_NORM;
      s_d.exit_req = 1'b0;
      s_d.hyst_cnt = s_q.hyst;
      s_d.loop_hold = 1'b1;
      s_d.m_start = 1'b0;
      s_d.l_start = 1'b0;
      s_d.l_abort = (s_q.st == ST_LP);
      s_d.i_cnt = 3'h0;
      s_d.v_cnt = 7'h00;
    end

    // Register reads, data one cycle later
    if (rd_stb) begin
      case (addr)
        A_STAT: begin
          s_d.rdata[ST_SLEEP_EN] = s_q.sleep_en;
          s_d.rdata[ST_SLEEP] = in_sleep;
        end
        A_PCFG:  s_d.rdata = {10'h000, s_q.pcfg};
        A_SLPI:  s_d.rdata = s_q.slp_i;
        A_WAKI:  s_d.rdata = s_q.wak_i;
        A_VTIME: s_d.rdata = {8'h00, s_q.vtime};
        A_HYST:  s_d.rdata = {8'h00, s_q.hyst};
        A_DELTA: s_d.rdata = s_q.delta;
        A_CHGV:  s_d.rdata = s_q.chgv;
        default: s_d.rdata = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // Register and shutdown
  // ----------------------------------------
  // Shutdown wipes every setting, as a power loss would
  always_ff @(posedge sys_clk) begin
    if (rst || shutdown_req) begin
      s_q <= '0;
      s_q.st <= ST_NORM;
      s_q.pcfg <= PCFG_RST;
      s_q.sleep_en <= PCFG_RST[PC_SLEEP];
      s_q.slp_i <= SLPI_RST;
      s_q.wak_i <= WAKI_RST;
      s_q.vtime <= VTIME_RST;
      s_q.hyst <= HYST_RST;
      s_q.delta <= DELTA_RST;
      s_q.chgv <= CHGV_RST;
      s_q.shut <= shutdown_req && !rst;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata = s_q.rdata;
  assign sleep_mode = in_sleep;
  assign i_sample = s_q.i_smp && !s_q.shut;
  assign v_sample = s_q.v_smp && !s_q.shut;
  assign half_res = s_q.pcfg[PC_FAST];
  assign wake_sample = s_q.wk_smp;
  assign meas_start = s_q.m_start;
  assign lp_start = s_q.l_start;
  assign lp_abort = s_q.l_abort;
  assign temp_eval = s_q.t_eval;
  assign loop_run = !in_sleep && !s_q.loop_hold && !s_q.shut;
  assign tick_1s = s_q.sec;
  // Comparator protections run alike in both modes
  assign cmp_prot_en = !s_q.shut;
  // Sleep FET drive options; shutdown forces all off but the discharge follower
  assign discharge_switch = !s_q.shut;
  assign discharge_follower = in_sleep && s_q.pcfg[PC_FOLLOW];
  assign charge_switch = !s_q.shut && (!in_sleep || s_q.pcfg[PC_CHGDRV]);
  assign precharge_switch = 1'b0;
  assign predischarge_switch = 1'b0;
  assign first_regulator = !s_q.shut;
  assign second_regulator = !s_q.shut;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  entry_on_second_a: assert property ($rose(sleep_mode) |-> $past(s_q.sec))
    else $error("sleep entered off the second boundary");
  entry_allowed_a: assert property ($rose(sleep_mode) |-> $past(s_q.sleep_en) && $past(s_q.hyst_cnt) == 8'h00)
    else $error("sleep entered without permission or during hysteresis");
  entry_low_i_a: assert property ($rose(sleep_mode) |-> $past(mag(cc_current)) < $past(s_q.slp_i))
    else $error("sleep entered with high current");
  status_read_a: assert property (rd_stb && addr == A_STAT |=> rdata[ST_SLEEP] == $past(in_sleep))
    else $error("status sleep bit wrong");
  enable_cmd_a: assert property (wr_stb && addr == A_CMD && wdata == SUB_SLP_DIS && !shutdown_req |=> !s_q.sleep_en)
    else $error("disable subcommand ignored");
  wake_fast_a: assert property (wake_hit && !shutdown_req |=> !sleep_mode && charge_switch && !loop_run)
    else $error("wake comparator exit late");
  abort_meas_a: assert property (lp_abort && sleep_mode |-> meas_start)
    else $error("abort without full measurement set");
  lp_after_gap_a: assert property (lp_start |-> $past(s_q.st) == ST_GAP && $past(s_q.sec))
    else $error("integration started off schedule");
  shut_off_a: assert property (shutdown_req |=> !first_regulator && !discharge_switch && !charge_switch)
    else $error("shutdown left outputs on");
  sleep_temp_a: assert property (sleep_mode && $past(sleep_mode) && temp_eval |-> $past(meas_done))
    else $error("sleep temperature check without measurement");

  enter_c: cover property ($rose(sleep_mode));
  wake_c: cover property (wake_hit);
  abort_c: cover property (lp_abort && sleep_mode);

endmodule : sleep_ctrl
`default_nettype wire

// File: core/sleep_pkg.sv
// Constants for the battery monitor sleep mode controller.
// Assumes a 20 MHz system clock and a plain register port.
package sleep_pkg;
  // ----------------------------------------
  // Clock and time base
  // ----------------------------------------
  localparam int CLK_NS      = 50;       // 20 MHz
  localparam int TICK_NS     = 500_000;  // 0.5 ms base tick
  localparam int TICK_CYC    = TICK_NS / CLK_NS;
  localparam int I_MS_X2     = 6;        // 3 ms current sample, in ticks
  localparam int V_MS_X2     = 126;      // 63 ms voltage sample, in ticks
  localparam int SEC_TICKS   = 2000;     // 1 s boundary
  localparam int LP_SECS     = 4;        // Low power current measurement
  localparam int GAP_SECS    = 1;        // Wait before low power measurement
  // Wake comparator periods 48/24/12/6 ms in ticks
  localparam logic [6:0] WK_P0 = 7'h60;
  localparam logic [6:0] WK_P1 = 7'h30;
  localparam logic [6:0] WK_P2 = 7'h18;
  localparam logic [6:0] WK_P3 = 7'h0C;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] A_CMD    = 8'h00;  // Subcommand write
  localparam logic [7:0] A_STAT   = 8'h12;  // Battery status
  localparam logic [7:0] A_PCFG   = 8'h20;  // Power config
  localparam logic [7:0] A_SLPI   = 8'h22;  // Sleep current
  localparam logic [7:0] A_WAKI   = 8'h24;  // Wake comparator current
  localparam logic [7:0] A_VTIME  = 8'h26;  // Voltage time, s
  localparam logic [7:0] A_HYST   = 8'h28;  // Hysteresis time, s
  localparam logic [7:0] A_DELTA  = 8'h2A;  // Pack minus stack delta
  localparam logic [7:0] A_CHGV   = 8'h2C;  // Charger voltage threshold
  localparam logic [15:0] SUB_SLP_EN  = 16'h0099;
  localparam logic [15:0] SUB_SLP_DIS = 16'h009A;

  // Status and config bit positions
  localparam int ST_SLEEP_EN = 0;
  localparam int ST_SLEEP    = 1;
  localparam int PC_SLEEP    = 0;
  localparam int PC_FAST     = 1;
  localparam int PC_WK_LO    = 2;
  localparam int PC_CHGDRV   = 4;
  localparam int PC_FOLLOW   = 5;

  // Reset values
  localparam logic [5:0]  PCFG_RST  = 6'h09;  // sleep allowed, wake rate 2
  localparam logic [15:0] SLPI_RST  = 16'h0014;
  localparam logic [15:0] WAKI_RST  = 16'h01F4;
  localparam logic [7:0]  VTIME_RST = 8'h05;
  localparam logic [7:0]  HYST_RST  = 8'h0A;
  localparam logic [15:0] DELTA_RST = 16'h00C8;
  localparam logic [15:0] CHGV_RST  = 16'h0FA0;

  // Mode states, gray along entry, measure, gap, integrate, idle
  typedef enum logic [2:0] {
    ST_NORM = 3'b000,
    ST_MEAS = 3'b001,
    ST_GAP  = 3'b011,
    ST_LP   = 3'b010,
    ST_IDLE = 3'b110
  } mode_e;
endpackage : sleep_pkg

// File: bench/meas_model.sv
// Model of the measurement engine beside the sleep controller.
// Assumes meas_start arrives as a one-cycle pulse in the sys_clk domain.
`timescale 1ns/1ns
`default_nettype none
module meas_model #(
  parameter int SET_CYC = 20
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        meas_start,
  input  wire logic [15:0] lp_level,
  output logic             meas_done,
  output logic      [15:0] lp_current
);
  // ----------------------------------------
  // Full measurement set
  // ----------------------------------------
  int cnt;
  // A new request restarts the set, so an aborted one never reports done
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt <= 0;
    end else if (meas_start) begin
      cnt <= SET_CYC;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  assign meas_done = (cnt == 1);
  // Integration result is the charge level the bench sets up
  assign lp_current = lp_level;
endmodule : meas_model
`default_nettype wire

// File: bench/test_sleep_ctrl.sv
// Testbench for the sleep controller: register port, schedule, wake and exits.
// Assumes the measurement model answers sets; the tick is shortened to TK clocks.
`timescale 1ns/1ns
`default_nettype none
module test_sleep_ctrl
  import sleep_pkg::*;
;
  localparam int TK  = 1;
  localparam int SEC = SEC_TICKS * TK;
  logic        sys_clk = 0, rst = 1, wr_stb = 0, rd_stb = 0, meas_done;
  logic        cmp_fault = 0, fw_fault = 0, rst_pin_short = 0, shutdown_req = 0;
  logic [7:0]  addr = 0;
  logic [15:0] wdata = 0, rdata, cc_current = 0, lp_current, lp_level = 0;
  logic [15:0] pack_mv = 16'h0BB8, stack_mv = 16'h0BB8;
  logic        sleep_mode, i_sample, v_sample, half_res, wake_sample, meas_start;
  logic        lp_start, lp_abort, temp_eval, loop_run, tick_1s, cmp_prot_en;
  logic        discharge_switch, discharge_follower, charge_switch, precharge_switch;
  logic        predischarge_switch, first_regulator, second_regulator;
  int          n_fail = 0, checked = 0;
  logic [7:0]  ra [9] = '{A_PCFG, A_SLPI, A_WAKI, A_VTIME, A_HYST, A_DELTA, A_CHGV, 8'h30, A_STAT};
  logic [15:0] re [9] = '{{10'h000, PCFG_RST}, SLPI_RST, WAKI_RST, {8'h00, VTIME_RST}, {8'h00, HYST_RST},
                          DELTA_RST, CHGV_RST, 16'h0000, 16'h0001};

  sleep_ctrl #(.TICK_CYCLES(TK)) dut (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .cc_current(cc_current), .lp_current(lp_current),
    .meas_done(meas_done), .pack_mv(pack_mv), .stack_mv(stack_mv), .cmp_fault(cmp_fault),
    .fw_fault(fw_fault), .rst_pin_short(rst_pin_short), .shutdown_req(shutdown_req),
    .sleep_mode(sleep_mode), .i_sample(i_sample), .v_sample(v_sample), .half_res(half_res),
    .wake_sample(wake_sample), .meas_start(meas_start), .lp_start(lp_start), .lp_abort(lp_abort),
    .temp_eval(temp_eval), .loop_run(loop_run), .tick_1s(tick_1s), .cmp_prot_en(cmp_prot_en),
    .discharge_switch(discharge_switch), .discharge_follower(discharge_follower),
    .charge_switch(charge_switch), .precharge_switch(precharge_switch),
    .predischarge_switch(predischarge_switch), .first_regulator(first_regulator),
    .second_regulator(second_regulator));
  meas_model model (.sys_clk(sys_clk), .rst(rst), .meas_start(meas_start), .lp_level(lp_level),
    .meas_done(meas_done), .lp_current(lp_current));

  // ----------------------------------------
  // Clock, watchdog and shared helpers
  // ----------------------------------------
  always #25 sys_clk = ~sys_clk;
  // Longest run is about 30 s of device time; this leaves margin
  initial begin
    repeat (45 * SEC) @(posedge sys_clk);
    n_fail++;
    $display("unexpected at %0t ns: watchdog expired", $time);
    conclude();
  end
  // Watched outputs: 0 i, 1 v, 2 wake, 3 temp, 4 lp start, 5 meas start, 6 sleep, 7 loop, 8 second
  function automatic logic pick(input int i);
    case (i)
      0: return i_sample;
      1: return v_sample;
      2: return wake_sample;
      3: return temp_eval;
      4: return lp_start;
      5: return meas_start;
      6: return sleep_mode;
      7: return loop_run;
      default: return tick_1s;
    endcase
  endfunction : pick
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t ns: got %h, expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    @(negedge sys_clk);
    d = rdata;
  endtask : rd
  // Outputs are looked at on the falling edge, where they have settled
  task automatic wt(input int i, input logic v, input int lim, input bit must, output int n);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (pick(i) !== v && n < lim);
    if (must && pick(i) !== v) begin
      n_fail++;
      $display("unexpected at %0t ns: wait ran out", $time);
    end
  endtask : wt
  // Two alignment pulses first, so a rate change has settled before measuring
  task automatic per(input int i, input int e);
    int n;
    repeat (3) wt(i, 1'b1, 2 * e + 4, 1'b1, n);
    chk(16'(n), 16'(e));
  endtask : per
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [15:0] d;
    for (int k = 0; k < 9; k++) begin
      rd(ra[k], d);
      chk(d, re[k]);
    end
    $display("register reset test done");
  endtask : t_regs
  task automatic t_rates();
    per(0, 6 * TK);
    per(1, 126 * TK);
    wr(A_PCFG, 16'h000B);
    per(0, 3 * TK);
    per(1, 63 * TK);
    chk(16'(half_res), 16'h0001);
    wr(A_PCFG, 16'h0009);
    $display("normal rate test done");
  endtask : t_rates
  task automatic t_entry();
    logic [15:0] d;
    int          n;
    wr(A_HYST, 16'h0000);
    wr(A_VTIME, 16'h0003);
    wr(A_CMD, SUB_SLP_DIS);
    rd(A_STAT, d);
    chk(d, 16'h0000);
    per(8, SEC);
    wt(6, 1'b1, SEC + SEC / 2, 1'b0, n);
    chk(16'(n), 16'(SEC + SEC / 2));
    wr(A_CMD, SUB_SLP_EN);
    wt(6, 1'b1, 12 * SEC, 1'b1, n);
    chk(16'(meas_start), 16'h0001);
    $display("sleep entry test done");
  endtask : t_entry
  // Called right at entry: cycle counts start with the entry measurement
  task automatic t_sched();
    logic [15:0] d;
    int          n1, n2, n3;
    wt(3, 1'b1, 60, 1'b1, n1);
    wt(4, 1'b1, SEC + 10, 1'b1, n2);
    wt(5, 1'b1, 3 * SEC, 1'b1, n3);
    chk(16'(n1 + n2 + n3), 16'(3 * SEC));
    chk(16'(lp_abort), 16'h0001);
    rd(A_STAT, d);
    chk(d, 16'h0003);
    for (int k = 0; k < 4; k++) begin
      // Fastest rate only with a raised wake threshold, against noise wakeups
      if (k == 3) wr(A_WAKI, 16'h0400);
      wr(A_PCFG, {10'h000, k[0] ? 2'b10 : 2'b01, k[1:0], 2'b01});
      per(2, (96 >> k) * TK);
      chk({14'h0000, charge_switch, discharge_follower}, k[0] ? 16'h0001 : 16'h0002);
    end
    chk({14'h0000, cmp_prot_en, discharge_switch}, 16'h0003);
    wr(A_WAKI, WAKI_RST);
    wr(A_PCFG, 16'h0001);
    $display("sleep schedule test done");
  endtask : t_sched
  task automatic t_wake();
    int n;
    wr(A_HYST, 16'h0004);
    @(posedge sys_clk);
    cc_current <= 16'hFD00;
    wt(6, 1'b0, 2 * 96 * TK + 4, 1'b1, n);
    chk({14'h0000, charge_switch, loop_run}, 16'h0002);
    @(posedge sys_clk);
    cc_current <= 16'h0000;
    wt(7, 1'b1, SEC + 4, 1'b1, n);
    wt(6, 1'b1, SEC + SEC / 2, 1'b0, n);
    chk(16'(n), 16'(SEC + SEC / 2));
    wt(6, 1'b1, 4 * SEC, 1'b1, n);
    $display("wake and hysteresis test done");
  endtask : t_wake
  task automatic t_causes();
    logic [15:0] d;
    int          n;
    wr(A_HYST, 16'h0000);
    for (int c = 0; c < 5; c++) begin
      @(posedge sys_clk);
      if (c == 4) pack_mv <= 16'h1388;
      wt(6, 1'b1, 2 * SEC, 1'b1, n);
      @(posedge sys_clk);
      cmp_fault     <= (c == 0);
      fw_fault      <= (c == 1);
      rst_pin_short <= (c == 2);
      if (c == 3) wr(A_CMD, SUB_SLP_DIS);
      wt(6, 1'b0, SEC + 40, 1'b1, n);
      @(posedge sys_clk);
      {cmp_fault, fw_fault, rst_pin_short} <= 3'b000;
      pack_mv <= 16'h0BB8;
      if (c == 3) begin
        rd(A_STAT, d);
        chk(d, 16'h0000);
        wr(A_CMD, SUB_SLP_EN);
      end
    end
    $display("exit cause test done");
  endtask : t_causes
  task automatic t_lp();
    int n;
    wr(A_VTIME, 16'h0005);
    @(posedge sys_clk);
    lp_level <= 16'h0020;
    wt(6, 1'b1, 2 * SEC, 1'b1, n);
    wt(6, 1'b0, 7 * SEC, 1'b1, n);
    @(posedge sys_clk);
    lp_level <= 16'h0000;
    $display("integrated current exit test done");
  endtask : t_lp
  task automatic t_shut();
    logic [15:0] d;
    @(posedge sys_clk);
    shutdown_req <= 1'b1;
    repeat (2) @(negedge sys_clk);
    chk({10'h000, first_regulator, second_regulator, discharge_switch, charge_switch, cmp_prot_en,
         loop_run}, 16'h0000);
    @(posedge sys_clk);
    shutdown_req <= 1'b0;
    rd(A_VTIME, d);
    chk(d, {8'h00, VTIME_RST});
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk({13'h0000, first_regulator, precharge_switch, predischarge_switch}, 16'h0004);
    $display("shutdown test done");
  endtask : t_shut

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_rates();
    t_entry();
    t_sched();
    t_wake();
    t_causes();
    t_lp();
    t_shut();
    conclude();
  end
endmodule : test_sleep_ctrl
`default_nettype wire
